// [design/iatc_sync.sv]
`default_nettype none

// two-flop synchroniser; only the second flop is read outside
module iatc_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk_i,
  // asynchronous data in, synchronised data out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;  // metastable stage
    logic [W-1:0] s2;  // settled stage
  } iatc_sync_s;

  iatc_sync_s r;
  iatc_sync_s next_r;

  // shift the input through both stages
  always_comb begin
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_i) begin
    r <= next_r;
  end

  assign q_o = r.s2;

endmodule // iatc_sync
`default_nettype wire

// [design/iatc_top.sv]
`default_nettype none

// Notes on behaviour
// - switches open until enabled, sampled, both idle
// - idle means stop seen or lines high 120us
// - then close switches and raise ready
// - pass-through keeps switches closed, no translation
// - pass-through aborts address translation immediately
// - bit advances while clock low, 100ns after fall
// - start on one bit shows downstream stop
// - start on zero bit passes unchanged
// - after stray start, return idle at stop
// - stop in address aborts, stop reaches downstream
// - stop on one bit: disconnect, generate stop
// - clock stuck 30ms aborts and reconnects data
// - lower select bits 3..0, upper 6..4
// - sample selects on leaving shutdown, once enabled without undervoltage
// - disable or undervoltage clears and opens all
module iatc_top #(
  parameter int unsigned IDLE_CYC = iatc_pkg::IDLE_CYC,
  parameter int unsigned STUCK_CYC = iatc_pkg::STUCK_CYC
) (
  // clocks and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  // control pins
  input wire logic enable_i,
  input wire logic undervoltage_i,
  input wire logic [iatc_pkg::LO_W-1:0] lower_translation_select_i,
  input wire logic [iatc_pkg::HI_W-1:0] upper_translation_select_i,
  input wire logic upper_select_high_i,
  // bus pins, levels as seen
  input wire logic upstream_clock_line_i,
  input wire logic upstream_data_line_i,
  input wire logic downstream_clock_line_i,
  input wire logic downstream_data_line_i,
  // switches and status
  output logic input_output_switches_o,
  output logic data_line_switch_pair_o,
  output logic ready_o,
  // downstream data drive, open drain
  output logic downstream_data_line_o,
  output logic downstream_data_line_oe_o
);

  // ----------------------------------------------------------------------
  // link domain: bus condition detection
  // ----------------------------------------------------------------------
  localparam int PN = iatc_pkg::PIN_N;
  localparam int EN = iatc_pkg::EV_N;

  logic [PN:0] lnk_q;  // synced {reset, pins}

  // pins and reset enter the link clock domain
  iatc_sync #(.W(PN + 1)) u_lnk_sync (
    .clk_i(link_clk_i),
    .d_i({rst_i, downstream_data_line_i, downstream_clock_line_i,
          upstream_data_line_i, upstream_clock_line_i}),
    .q_o(lnk_q)
  );

  typedef struct packed {
    logic [PN-1:0] prev;  // pin levels one link cycle ago
    logic [EN-1:0] tog;   // one toggle per bus event
  } iatc_link_s;

  iatc_link_s l;
  iatc_link_s next_l;

  // start, stop and clock edges become toggles for the core
  always_comb begin
    next_l = l;
    next_l.prev = lnk_q[PN-1:0];
    if (lnk_q[PN]) begin
      next_l.prev = 4'hf;
      next_l.tog = 5'h00;
    end else begin
      // data falls while clock high: start
      if (l.prev[iatc_pkg::PIN_SCL_UP] && lnk_q[iatc_pkg::PIN_SCL_UP] &&
          l.prev[iatc_pkg::PIN_SDA_UP] && !lnk_q[iatc_pkg::PIN_SDA_UP]) begin
        next_l.tog[iatc_pkg::EV_START] = !l.tog[iatc_pkg::EV_START];
      end
      // data rises while clock high: stop
      if (l.prev[iatc_pkg::PIN_SCL_UP] && lnk_q[iatc_pkg::PIN_SCL_UP] &&
          !l.prev[iatc_pkg::PIN_SDA_UP] && lnk_q[iatc_pkg::PIN_SDA_UP]) begin
        next_l.tog[iatc_pkg::EV_STOP] = !l.tog[iatc_pkg::EV_STOP];
      end
      // stop on the downstream side
      if (l.prev[iatc_pkg::PIN_SCL_DN] && lnk_q[iatc_pkg::PIN_SCL_DN] &&
          !l.prev[iatc_pkg::PIN_SDA_DN] && lnk_q[iatc_pkg::PIN_SDA_DN]) begin
        next_l.tog[iatc_pkg::EV_DSTOP] = !l.tog[iatc_pkg::EV_DSTOP];
      end
      // upstream clock edges
      if (l.prev[iatc_pkg::PIN_SCL_UP] && !lnk_q[iatc_pkg::PIN_SCL_UP]) begin
        next_l.tog[iatc_pkg::EV_SFALL] = !l.tog[iatc_pkg::EV_SFALL];
      end
      if (!l.prev[iatc_pkg::PIN_SCL_UP] && lnk_q[iatc_pkg::PIN_SCL_UP]) begin
        next_l.tog[iatc_pkg::EV_SRISE] = !l.tog[iatc_pkg::EV_SRISE];
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    l <= next_l;
  end

  // ----------------------------------------------------------------------
  // core domain: inputs
  // ----------------------------------------------------------------------
  localparam int CW = EN + iatc_pkg::XOR_W + 3 + PN;

  logic [CW-1:0] core_q;              // synced pins, controls, toggles
  logic [PN-1:0] pin_q;               // bus levels
  logic en_q;                         // enable level
  logic uv_q;                         // undervoltage level
  logic thru_q;                       // pass-through request
  logic [iatc_pkg::XOR_W-1:0] sel_q;  // {upper, lower} selects
  logic [EN-1:0] tog_q;               // event toggles
  logic [EN-1:0] ev;                  // one-cycle events

  iatc_sync #(.W(CW)) u_core_sync (
    .clk_i(clk_i),
    .d_i({l.tog, upper_translation_select_i, lower_translation_select_i,
          upper_select_high_i, undervoltage_i, enable_i,
          downstream_data_line_i, downstream_clock_line_i,
          upstream_data_line_i, upstream_clock_line_i}),
    .q_o(core_q)
  );

  assign pin_q = core_q[PN-1:0];
  assign en_q = core_q[PN];
  assign uv_q = core_q[PN+1];
  assign thru_q = core_q[PN+2];
  assign sel_q = core_q[PN+3+:iatc_pkg::XOR_W];
  assign tog_q = core_q[CW-1-:EN];

  typedef struct packed {
    iatc_pkg::iatc_state_e st;          // translation state
    logic [iatc_pkg::XOR_W-1:0] xor_val; // stored translation value
    logic [2:0] idx;                    // address bits applied
    logic cur_bit;                      // active translating bit
    logic pend;                         // bit change pending
    iatc_pkg::iatc_cnt_t dly;           // shift and gap delay
    iatc_pkg::iatc_cnt_t tmo;           // stuck clock timer
    iatc_pkg::iatc_cnt_t hi_up;         // upstream high time
    iatc_pkg::iatc_cnt_t hi_dn;         // downstream high time
    logic up_idle;                      // upstream seen idle
    logic dn_idle;                      // downstream seen idle
    logic [EN-1:0] tog_prev;            // toggles last cycle
    logic sw;                           // main switches closed
    logic dsw;                          // data switch pair closed
    logic rdy;                          // ready
    logic dd;                           // downstream data level
    logic dd_oe;                        // downstream data pull low
  } iatc_core_s;

  iatc_core_s r;
  iatc_core_s next_r;
  logic drive;  // device owns the downstream data line

  assign ev = tog_q ^ r.tog_prev;

  // ----------------------------------------------------------------------
  // core domain: translation control
  // ----------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.tog_prev = tog_q;
    // idle high-time counters, saturating
    if (!(pin_q[iatc_pkg::PIN_SCL_UP] && pin_q[iatc_pkg::PIN_SDA_UP])) begin
      next_r.hi_up = '0;
    end else if (r.hi_up < iatc_pkg::iatc_cnt_t'(IDLE_CYC)) begin
      next_r.hi_up = r.hi_up + 1'b1;
    end
    if (!(pin_q[iatc_pkg::PIN_SCL_DN] && pin_q[iatc_pkg::PIN_SDA_DN])) begin
      next_r.hi_dn = '0;
    end else if (r.hi_dn < iatc_pkg::iatc_cnt_t'(IDLE_CYC)) begin
      next_r.hi_dn = r.hi_dn + 1'b1;
    end
    // stuck timer runs in the address byte, cleared by clock edges
    if (r.st != iatc_pkg::S_ADDR || ev[iatc_pkg::EV_SFALL] ||
        ev[iatc_pkg::EV_SRISE]) begin
      next_r.tmo = '0;
    end else if (r.tmo < iatc_pkg::iatc_cnt_t'(STUCK_CYC)) begin
      next_r.tmo = r.tmo + 1'b1;
    end
    unique case (r.st)
      // shut down: sample selects when enabled
      iatc_pkg::S_OFF: begin
        if (en_q && !uv_q) begin
          next_r.xor_val = sel_q;
          next_r.up_idle = 1'b0;
          next_r.dn_idle = 1'b0;
          next_r.st = iatc_pkg::S_WAIT;
        end
      end
      // switches open until both sides idle
      iatc_pkg::S_WAIT: begin
        if (ev[iatc_pkg::EV_STOP] ||
            r.hi_up >= iatc_pkg::iatc_cnt_t'(IDLE_CYC)) begin
          next_r.up_idle = 1'b1;
        end
        if (ev[iatc_pkg::EV_DSTOP] ||
            r.hi_dn >= iatc_pkg::iatc_cnt_t'(IDLE_CYC)) begin
          next_r.dn_idle = 1'b1;
        end
        if (next_r.up_idle && next_r.dn_idle) begin
          next_r.st = iatc_pkg::S_IDLE;
        end
      end
      // connected, waiting for a start
      iatc_pkg::S_IDLE: begin
        if (ev[iatc_pkg::EV_START]) begin
          next_r.st = iatc_pkg::S_ADDR;
          next_r.idx = 3'h0;
          next_r.cur_bit = 1'b0;
          next_r.pend = 1'b0;
        end
      end
      // address byte: step the translating bit
      iatc_pkg::S_ADDR: begin
        if (ev[iatc_pkg::EV_STOP]) begin
          next_r.st = r.cur_bit ? iatc_pkg::S_LOW : iatc_pkg::S_IDLE;
          next_r.cur_bit = 1'b0;
          next_r.pend = 1'b0;
          next_r.dly = '0;
        end else if (ev[iatc_pkg::EV_START]) begin
          next_r.st = iatc_pkg::S_WSTOP;
          next_r.pend = 1'b0;
        end else if (r.tmo >= iatc_pkg::iatc_cnt_t'(STUCK_CYC)) begin
          next_r.st = iatc_pkg::S_IDLE;
          next_r.cur_bit = 1'b0;
          next_r.pend = 1'b0;
        end else if (ev[iatc_pkg::EV_SFALL]) begin
          next_r.pend = 1'b1;
          next_r.dly = '0;
        end else if (r.pend) begin
          if (r.dly == iatc_pkg::iatc_cnt_t'(iatc_pkg::SHIFT_CYC - 1)) begin
            next_r.pend = 1'b0;
            if (r.idx == iatc_pkg::IDX_LAST) begin
              next_r.st = iatc_pkg::S_BYTE;
              next_r.cur_bit = 1'b0;
            end else begin
              next_r.cur_bit = r.xor_val[iatc_pkg::IDX_TOP - r.idx];
              next_r.idx = r.idx + 3'h1;
            end
          end else begin
            next_r.dly = r.dly + 1'b1;
          end
        end
      end
      // rest of message passes plain
      iatc_pkg::S_BYTE: begin
        if (ev[iatc_pkg::EV_STOP]) begin
          next_r.st = iatc_pkg::S_IDLE;
        end else if (ev[iatc_pkg::EV_START]) begin
          next_r.st = iatc_pkg::S_ADDR;
          next_r.idx = 3'h0;
          next_r.cur_bit = 1'b0;
          next_r.pend = 1'b0;
        end
      end
      // stray start: hold the bit over this clock high, wait for stop
      iatc_pkg::S_WSTOP: begin
        if (ev[iatc_pkg::EV_SFALL]) begin
          next_r.cur_bit = 1'b0;
        end
        if (ev[iatc_pkg::EV_STOP]) begin
          next_r.st = iatc_pkg::S_IDLE;
          next_r.cur_bit = 1'b0;
        end
      end
      // disconnected, downstream data held low
      iatc_pkg::S_LOW: begin
        if (r.dly == iatc_pkg::iatc_cnt_t'(iatc_pkg::GAP_CYC - 1)) begin
          next_r.st = iatc_pkg::S_REL;
          next_r.dly = '0;
        end else begin
          next_r.dly = r.dly + 1'b1;
        end
      end
      // data released: the rise is the stop, then reconnect
      iatc_pkg::S_REL: begin
        if (r.dly == iatc_pkg::iatc_cnt_t'(iatc_pkg::GAP_CYC - 1)) begin
          next_r.st = iatc_pkg::S_IDLE;
          next_r.dly = '0;
        end else begin
          next_r.dly = r.dly + 1'b1;
        end
      end
      // pass-through: leave once the request drops
      iatc_pkg::S_THRU: begin
        if (!thru_q) begin
          next_r.st = iatc_pkg::S_IDLE;
        end
      end
    endcase
    // pass-through overrides any translation at once
    if (thru_q && r.st != iatc_pkg::S_OFF && r.st != iatc_pkg::S_WAIT) begin
      next_r.st = iatc_pkg::S_THRU;
      next_r.cur_bit = 1'b0;
      next_r.pend = 1'b0;
    end
    // shutdown overrides everything
    if (!en_q || uv_q) begin
      next_r.st = iatc_pkg::S_OFF;
      next_r.xor_val = iatc_pkg::XOR_RST;
      next_r.cur_bit = 1'b0;
      next_r.pend = 1'b0;
    end
    // outputs follow the next state
    drive = next_r.st == iatc_pkg::S_ADDR ||
            (next_r.st == iatc_pkg::S_WSTOP && next_r.cur_bit);
    next_r.sw = !(next_r.st inside {iatc_pkg::S_OFF, iatc_pkg::S_WAIT,
                                    iatc_pkg::S_LOW, iatc_pkg::S_REL});
    next_r.dsw = next_r.sw && !drive;
    next_r.rdy = !(next_r.st inside {iatc_pkg::S_OFF, iatc_pkg::S_WAIT});
    // drive low when upstream xor bit is zero
    next_r.dd_oe = drive ?
                   !(pin_q[iatc_pkg::PIN_SDA_UP] ^ next_r.cur_bit) :
                   next_r.st == iatc_pkg::S_LOW;
    next_r.dd = 1'b0;
    // synchronous reset
    if (rst_i) begin
      next_r = '0;
      next_r.st = iatc_pkg::S_OFF;
      next_r.xor_val = iatc_pkg::XOR_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    r <= next_r;
  end

  // registered outputs
  assign input_output_switches_o = r.sw;
  assign data_line_switch_pair_o = r.dsw;
  assign ready_o = r.rdy;
  assign downstream_data_line_o = r.dd;
  assign downstream_data_line_oe_o = r.dd_oe;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_off_clears: assert property (
    !en_q |=> !ready_o && !input_output_switches_o &&
              r.xor_val == iatc_pkg::XOR_RST)
    else $error("shutdown left switches, ready or value set");

  a_ready_after_wait: assert property (
    $rose(ready_o) |-> $past(r.st) == iatc_pkg::S_WAIT &&
                       $past(next_r.up_idle) && $past(next_r.dn_idle))
    else $error("ready rose without both sides idle");

  a_sample_select: assert property (
    $past(r.st) == iatc_pkg::S_OFF && r.st == iatc_pkg::S_WAIT |->
      r.xor_val == $past(sel_q))
    else $error("translation value not sampled on enable");

  a_thru_closed: assert property (
    r.st == iatc_pkg::S_THRU |-> input_output_switches_o &&
      data_line_switch_pair_o && !downstream_data_line_oe_o)
    else $error("pass-through without closed switches");

  a_thru_abort: assert property (
    thru_q && en_q && !uv_q && r.st == iatc_pkg::S_ADDR |=>
      r.st == iatc_pkg::S_THRU && !r.cur_bit)
    else $error("pass-through did not abort translation");

  a_shift_clk_low: assert property (
    $past(r.st) == iatc_pkg::S_ADDR && r.idx != $past(r.idx) |->
      !$past(pin_q[iatc_pkg::PIN_SCL_UP]))
    else $error("translating bit changed while clock high");

  a_seven_bits: assert property (
    $past(r.st) == iatc_pkg::S_ADDR && r.st == iatc_pkg::S_BYTE |->
      $past(r.idx) == iatc_pkg::IDX_LAST && !r.cur_bit)
    else $error("address byte left before seven bits");

  a_start_keeps_bit: assert property (
    ev[iatc_pkg::EV_START] && !ev[iatc_pkg::EV_STOP] && en_q && !uv_q &&
    !thru_q && r.st == iatc_pkg::S_ADDR |=>
      r.st == iatc_pkg::S_WSTOP && r.cur_bit == $past(r.cur_bit))
    else $error("stray start changed the translating bit");

  a_stop_zero_bit: assert property (
    ev[iatc_pkg::EV_STOP] && en_q && !uv_q && !thru_q && !r.cur_bit &&
    r.st == iatc_pkg::S_ADDR |=> r.st == iatc_pkg::S_IDLE)
    else $error("stop on zero bit not passed through");

  a_stop_gen: assert property (
    $rose(r.st == iatc_pkg::S_LOW) && en_q && !thru_q |->
      (!input_output_switches_o && downstream_data_line_oe_o) [*8])
    else $error("stop generation did not hold data low");

  a_stuck_bound: assert property (
    r.st == iatc_pkg::S_ADDR && r.tmo >= iatc_pkg::iatc_cnt_t'(STUCK_CYC) &&
    !ev[iatc_pkg::EV_STOP] && !ev[iatc_pkg::EV_START] && en_q && !uv_q &&
    !thru_q |=> r.st == iatc_pkg::S_IDLE && data_line_switch_pair_o &&
    !downstream_data_line_oe_o)
    else $error("stuck clock did not abort translation");

  a_stray_idle: assert property (
    r.st == iatc_pkg::S_WSTOP && ev[iatc_pkg::EV_STOP] && en_q && !uv_q &&
    !thru_q |=> r.st == iatc_pkg::S_IDLE && !r.cur_bit)
    else $error("no return to idle after stray start");

  c_translate: cover property (
    r.st == iatc_pkg::S_ADDR ##1 r.st == iatc_pkg::S_BYTE);
  c_stop_gen: cover property (
    r.st == iatc_pkg::S_REL ##1 r.st == iatc_pkg::S_IDLE);
  c_thru: cover property ($rose(r.st == iatc_pkg::S_THRU));
  c_stray_start: cover property ($rose(r.st == iatc_pkg::S_WSTOP));

endmodule // iatc_top
`default_nettype wire

// [pkg/iatc_pkg.sv]
`default_nettype none
package iatc_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_NS = 8;             // core clock period
  localparam int unsigned T_IDLE_NS = 120000;     // bus-high idle time
  localparam int unsigned T_SHIFT_NS = 100;       // scl fall to new bit
  localparam int unsigned T_XING_NS = 60;         // pin to event latency
  localparam int unsigned T_STUCK_NS = 30000000;  // stuck clock timeout
  localparam int unsigned T_GAP_NS = 1000;        // stop generation phase
  // least times round up, longest times round down
  localparam int unsigned IDLE_CYC = (T_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SHIFT_CYC = (T_SHIFT_NS - T_XING_NS) / CLK_NS;
  localparam int unsigned STUCK_CYC = (T_STUCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------------
  localparam int CNT_W = 22;                      // timer width
  localparam int XOR_W = 7;                       // translation value
  localparam int LO_W = 4;                        // lower select field
  localparam int HI_W = 3;                        // upper select field
  localparam logic [XOR_W-1:0] XOR_RST = 7'h00;   // cleared value
  localparam logic [2:0] IDX_LAST = 3'h7;         // address bits done
  localparam logic [2:0] IDX_TOP = 3'h6;          // msb of address

  typedef logic [CNT_W-1:0] iatc_cnt_t;

  // ----------------------------------------------------------------------
  // pin and event positions
  // ----------------------------------------------------------------------
  localparam int PIN_SCL_UP = 0;
  localparam int PIN_SDA_UP = 1;
  localparam int PIN_SCL_DN = 2;
  localparam int PIN_SDA_DN = 3;
  localparam int PIN_N = 4;
  localparam int EV_START = 0;                    // upstream start
  localparam int EV_STOP = 1;                     // upstream stop
  localparam int EV_DSTOP = 2;                    // downstream stop
  localparam int EV_SFALL = 3;                    // upstream clock fall
  localparam int EV_SRISE = 4;                    // upstream clock rise
  localparam int EV_N = 5;

  // ----------------------------------------------------------------------
  // translation states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_OFF, S_WAIT, S_IDLE, S_ADDR, S_BYTE, S_WSTOP, S_LOW, S_REL, S_THRU
  } iatc_state_e;

endpackage
`default_nettype wire

// [test/iatc_bus_model.sv]
`default_nettype none

// upstream master and pulled-up downstream wires around the translator
module iatc_bus_model (
  // translator switch and drive outputs
  input wire logic sw_i,
  input wire logic dsw_i,
  input wire logic oe_i,
  // resolved bus levels
  output logic up_scl_o,
  output logic up_sda_o,
  output logic dn_scl_o,
  output logic dn_sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl = 1'b1; // master clock drive, high when released
  logic sda = 1'b1; // master data drive, high when released
  // ---------------------------------------------------------------------
  // wires
  // ---------------------------------------------------------------------
  // no slave pulls low, so upstream data equals the master's level
  assign up_scl_o = scl;
  assign up_sda_o = sda;
  // pull-ups: low only when the translator or a closed switch pulls
  assign dn_scl_o = ~(sw_i & ~scl);
  assign dn_sda_o = ~oe_i & ~(dsw_i & ~sda);
  // ---------------------------------------------------------------------
  // master bus cycles, 400 ns half bit
  // ---------------------------------------------------------------------
  // start: data falls while clock high
  task start();
    sda = 1'b1;
    scl = 1'b1;
    #400 sda = 1'b0;
    #400;
  endtask
  // one bit, data changes only while clock low; leaves clock high
  task automatic send(input logic v, output logic got);
    scl = 1'b0;
    #100 sda = v;
    #300 scl = 1'b1;
    #200 got = dn_sda_o;
    #200;
  endtask
  // stop: data rises while clock high; normally only after a byte
  task stop();
    scl = 1'b0;
    #100 sda = 1'b0;
    #300 scl = 1'b1;
    #400 sda = 1'b1;
    #400;
  endtask
endmodule // iatc_bus_model

`default_nettype wire

// [test/testbench.sv]
`default_nettype none

// top-level bench for the address translator control
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0; // core clock
  logic rst_i = 1'b1; // synchronous reset
  logic link_clk = 1'b0; // bus sampling clock
  logic enable = 1'b0; // enable pin
  logic uv = 1'b0; // undervoltage
  logic thru = 1'b0; // pass-through strap
  logic [3:0] lo = 4'h0; // lower select bits
  logic [2:0] hi = 3'h0; // upper select bits
  logic up_scl, up_sda, dn_scl, dn_sda, sw, dsw, rdy, oe, dd, b;
  logic [6:0] x, sa; // translation value, slave address
  int failures = 0;
  int check_count = 0;
  always #4 clk_i = ~clk_i;
  always #7.5 link_clk = ~link_clk;

  iatc_top #(.IDLE_CYC(20), .STUCK_CYC(200)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk),
    .enable_i(enable), .undervoltage_i(uv),
    .lower_translation_select_i(lo), .upper_translation_select_i(hi),
    .upper_select_high_i(thru), .upstream_clock_line_i(up_scl),
    .upstream_data_line_i(up_sda), .downstream_clock_line_i(dn_scl),
    .downstream_data_line_i(dn_sda), .input_output_switches_o(sw),
    .data_line_switch_pair_o(dsw), .ready_o(rdy),
    .downstream_data_line_o(dd), .downstream_data_line_oe_o(oe));

  iatc_bus_model i_bus (
    .sw_i(sw), .dsw_i(dsw), .oe_i(oe), .up_scl_o(up_scl),
    .up_sda_o(up_sda), .dn_scl_o(dn_scl), .dn_sda_o(dn_sda));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // wait cycles, then step just past the edge; shared by both processes
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // compare and count
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for a level
  task automatic wait_sig(ref logic s, input logic v);
    for (int k = 0; k < 3000 && s !== v; k++) tick(1);
  endtask
  // downstream byte: address bits xored with the translation value, read/write bit plain
  function automatic logic [7:0] exp_byte(input logic [6:0] xv,
                                          input logic [7:0] up);
    return up ^ {xv, 1'b0};
  endfunction
  // address byte, ack, data byte, stop
  task automatic xfer(input logic [6:0] xv, input logic [7:0] ab);
    logic [7:0] g, d;
    d = 8'($urandom);
    i_bus.start();
    for (int i = 7; i >= 0; i--) i_bus.send(ab[i], g[i]);
    chk("addr", exp_byte(xv, ab), g);
    i_bus.send(1'b1, g[0]);
    chk("ack", 8'h01, {7'h00, g[0]});
    for (int i = 7; i >= 0; i--) i_bus.send(d[i], g[i]);
    chk("data", d, g);
    i_bus.stop();
  endtask
  // end of run
  task final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------------
  initial begin
    tick(60000);
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    final_report();
  end

  // ---------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------
  initial begin
    void'($urandom(65));
    tick(20);
    rst_i = 1'b0;
    tick(50);
    chk("closed_early", 8'h00, {6'h00, sw, rdy});
    enable = 1'b1;
    wait_sig(rdy, 1'b1);
    chk("startup", 8'h03, {6'h00, sw, rdy});
    $display("test startup done");
    for (int i = 0; i < 4; i++) begin
      // shutdown by undervoltage or enable low
      if (i[0]) uv = 1'b1;
      else enable = 1'b0;
      tick(10);
      chk("shutdown", 8'h00, {6'h00, sw, rdy});
      uv = 1'b0;
      enable = 1'b0;
      // last value keeps bits 6 and 5 set and bit 0 clear for later tests
      x = (i == 0) ? 7'h00 : (i == 3) ? 7'h7e : 7'($urandom);
      sa = 7'($urandom);
      {hi, lo} = x;
      tick(4);
      enable = 1'b1;
      wait_sig(rdy, 1'b1);
      xfer(x, {sa ^ x, 1'($urandom)});
      $display("test translate %0d done", i);
    end
    // stray stop while translating bit is one
    i_bus.start();
    i_bus.send(1'b0, b);
    i_bus.stop();
    wait_sig(sw, 1'b0);
    chk("disconnect", 8'h02, {5'h00, sw, oe, dd});
    wait_sig(sw, 1'b1);
    chk("reconnect", 8'h01, {7'h00, sw});
    xfer(x, 8'($urandom));
    $display("test stray stop done");
    // stray start on a one bit (k=1), then on a zero bit (k=7)
    for (int k = 1; k <= 7; k += 6) begin
      i_bus.start();
      for (int j = 0; j < k; j++) i_bus.send(1'b1, b);
      i_bus.start();
      chk("stray_start", {7'h00, x[7-k]}, {7'h00, dn_sda});
      i_bus.stop();
      xfer(x, 8'($urandom));
    end
    $display("test stray start done");
    // general call through pass-through
    // raised inside an address byte while a one bit is applied
    i_bus.start();
    i_bus.send(1'b1, b);
    thru = 1'b1;
    tick(10);
    chk("thru_abort", 8'h02, {6'h00, dsw, oe});
    i_bus.stop();
    xfer(7'h00, 8'h00);
    chk("thru_switch", 8'h01, {7'h00, sw});
    thru = 1'b0;
    $display("test pass-through done");
    // clock stuck high inside address byte
    i_bus.start();
    i_bus.send(1'b1, b);
    tick(300);
    chk("stuck", 8'h02, {6'h00, dsw, oe});
    i_bus.stop();
    $display("test stuck clock done");
    final_report();
  end
endmodule // testbench

`default_nettype wire
